//--- design/bgs_pkg.sv
// Constants and carrier types for the buck global slew configuration register bank.
package bgs_pkg;

  // Register offsets on the internal control port.
  localparam logic [7:0] OFFSET_SLEW_A = 8'h33;
  localparam logic [7:0] OFFSET_SLEW_B = 8'h34;
  localparam logic [7:0] OFFSET_TRANSIENT = 8'h35;
  localparam logic [7:0] OFFSET_RESERVED_FIRST = 8'h36;
  localparam logic [7:0] OFFSET_RESERVED_LAST = 8'hff;

  // Reset values.
  localparam logic [7:0] RESET_SLEW_A = 8'h24;
  localparam logic [7:0] RESET_SLEW_B = 8'h24;
  localparam logic [7:0] RESET_TRANSIENT = 8'h5f;

  // Writable bits of each register; other bits keep their reset value.
  localparam logic [7:0] WRITE_MASK_SLEW = 8'h77;
  localparam logic [7:0] WRITE_MASK_TRANSIENT = 8'h03;
  localparam logic [7:0] RESERVED_READ_DATA = 8'h00;

  // Field positions.
  localparam int UPPER_SELECT_LSB = 4;
  localparam int LOWER_SELECT_LSB = 0;
  localparam int SELECT_WIDTH = 3;
  localparam int POSITIVE_BOOST_BIT = 1;
  localparam int NEGATIVE_BOOST_BIT = 0;

  // Slew rates in units of 0.01 mV/us.
  localparam int RATE_WIDTH = 13;
  localparam logic [12:0] RATE_CODE_0 = 13'h007d;
  localparam logic [12:0] RATE_CODE_1 = 13'h00fa;
  localparam logic [12:0] RATE_CODE_2 = 13'h01f4;
  localparam logic [12:0] RATE_CODE_3 = 13'h03e8;
  localparam logic [12:0] RATE_CODE_4 = 13'h07d0;
  localparam logic [12:0] RATE_CODE_5 = 13'h0fa0;
  localparam logic [12:0] RATE_CODE_MAX = 13'h1770;

  // Timing of the forced continuous switching hold after a ramp-down.
  localparam int CLOCK_PERIOD_PS = 4000;
  localparam int HOLD_TIME_NS = 50000;
  localparam int HOLD_CYCLES = (HOLD_TIME_NS * 1000 + CLOCK_PERIOD_PS - 1) / CLOCK_PERIOD_PS;
  localparam int HOLD_COUNT_WIDTH = 16;

  typedef struct packed {
    logic [7:0] addr;
    logic write;
    logic read;
    logic [7:0] writeData;
  } bgs_reg_req_type;

  typedef struct packed {
    logic [2:0] shutdown;
    logic [2:0] softstart;
    logic [2:0] rampdown;
    logic [2:0] rampup;
  } bgs_slew_sel_type;

  typedef struct packed {
    logic [12:0] shutdown;
    logic [12:0] softstart;
    logic [12:0] rampdown;
    logic [12:0] rampup;
  } bgs_slew_rate_type;

  typedef enum logic [1:0] {
    RAMP_IDLE,
    RAMP_ACTIVE,
    RAMP_HOLD
  } bgs_ramp_state_type;

endpackage

//--- design/bgs_slew_decode.sv
// Registered decoder from the four slew select codes to slew rates.
`timescale 1ns/10ps
module bgs_slew_decode
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Codes and rates
  input bgs_pkg::bgs_slew_sel_type selects,
  output bgs_pkg::bgs_slew_rate_type rates
);

  bgs_pkg::bgs_slew_rate_type rates_d;
  bgs_pkg::bgs_slew_rate_type rates_q;

  function automatic logic [12:0] decodeRate(input logic [2:0] code);
    case (code)
      3'h0: decodeRate = bgs_pkg::RATE_CODE_0;
      3'h1: decodeRate = bgs_pkg::RATE_CODE_1;
      3'h2: decodeRate = bgs_pkg::RATE_CODE_2;
      3'h3: decodeRate = bgs_pkg::RATE_CODE_3;
      3'h4: decodeRate = bgs_pkg::RATE_CODE_4;
      3'h5: decodeRate = bgs_pkg::RATE_CODE_5;
      default: decodeRate = bgs_pkg::RATE_CODE_MAX;
    endcase
  endfunction

  always_comb
  begin
    rates_d.shutdown = decodeRate(selects.shutdown);
    rates_d.softstart = decodeRate(selects.softstart);
    rates_d.rampdown = decodeRate(selects.rampdown);
    rates_d.rampup = decodeRate(selects.rampup);
  end

  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      rates_q <= '0;
    end
    else
    begin
      rates_q <= rates_d;
    end
  end

  assign rates = rates_q;

  property p_topCodesSaturate;
    @(posedge clock) disable iff (!rst_n)
    (selects.rampdown[2:1] == 2'h3) |=> (rates.rampdown == bgs_pkg::RATE_CODE_MAX);
  endproperty
  a_topCodesSaturate: assert property (p_topCodesSaturate) else $error("Codes 6 and 7 must give 60 mV/us.");

  property p_slowestCode;
    @(posedge clock) disable iff (!rst_n)
    (selects.shutdown == 3'h0) |=> (rates.shutdown == bgs_pkg::RATE_CODE_0);
  endproperty
  a_slowestCode: assert property (p_slowestCode) else $error("Code 0 must give 1.25 mV/us.");

endmodule // bgs_slew_decode

//--- design/bgs_config_regs.sv
// Buck global slew and transient response configuration registers with ramp-down hold control.
`timescale 1ns/10ps
module bgs_config_regs
#(
  parameter int HOLD_CYCLES = bgs_pkg::HOLD_CYCLES
)
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Register access port
  input bgs_pkg::bgs_reg_req_type regReq,
  output logic [7:0] regReadData,
  output logic regReadValid,
  // Configuration outputs
  output bgs_pkg::bgs_slew_sel_type slewSelects,
  output bgs_pkg::bgs_slew_rate_type slewRates,
  output logic positiveTransientBoostEnable,
  output logic negativeTransientBoostEnable,
  // Ramp-down switching control
  input wire logic fallingSlewControlEnable,
  input wire logic rampDownActive,
  output logic forceContinuousSwitching
);

  localparam logic [15:0] HOLD_LAST = 16'(HOLD_CYCLES - 1);

  logic [7:0] slewA_d;
  logic [7:0] slewA_q;
  logic [7:0] slewB_d;
  logic [7:0] slewB_q;
  logic [7:0] transient_d;
  logic [7:0] transient_q;
  logic [7:0] readData_d;
  logic [7:0] readData_q;
  logic readValid_d;
  logic readValid_q;

  bgs_pkg::bgs_ramp_state_type rampState_d;
  bgs_pkg::bgs_ramp_state_type rampState_q;
  logic [15:0] holdCount_d;
  logic [15:0] holdCount_q;
  logic force_d;
  logic force_q;

  // Reserved bits are forced to their reset values rather than stored, so a careless write cannot
  // reach undocumented analog trims behind them.
  function automatic logic [7:0] maskedWrite(input logic [7:0] data, input logic [7:0] mask,
                                             input logic [7:0] resetValue);
    maskedWrite = (data & mask) | (resetValue & ~mask);
  endfunction

  always_comb
  begin
    slewA_d = slewA_q;
    slewB_d = slewB_q;
    transient_d = transient_q;
    readData_d = readData_q;
    readValid_d = regReq.read;
    if (regReq.write)
    begin
      if (regReq.addr == bgs_pkg::OFFSET_SLEW_A)
      begin
        slewA_d = maskedWrite(regReq.writeData, bgs_pkg::WRITE_MASK_SLEW, bgs_pkg::RESET_SLEW_A);
      end
      else if (regReq.addr == bgs_pkg::OFFSET_SLEW_B)
      begin
        slewB_d = maskedWrite(regReq.writeData, bgs_pkg::WRITE_MASK_SLEW, bgs_pkg::RESET_SLEW_B);
      end
      else if (regReq.addr == bgs_pkg::OFFSET_TRANSIENT)
      begin
        transient_d = maskedWrite(regReq.writeData, bgs_pkg::WRITE_MASK_TRANSIENT,
                                  bgs_pkg::RESET_TRANSIENT);
      end
    end
    if (regReq.read)
    begin
      if (regReq.addr == bgs_pkg::OFFSET_SLEW_A)
      begin
        readData_d = slewA_q;
      end
      else if (regReq.addr == bgs_pkg::OFFSET_SLEW_B)
      begin
        readData_d = slewB_q;
      end
      else if (regReq.addr == bgs_pkg::OFFSET_TRANSIENT)
      begin
        readData_d = transient_q;
      end
      else
      begin
        readData_d = bgs_pkg::RESERVED_READ_DATA;
      end
    end
  end

  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      slewA_q <= bgs_pkg::RESET_SLEW_A;
      slewB_q <= bgs_pkg::RESET_SLEW_B;
      transient_q <= bgs_pkg::RESET_TRANSIENT;
      readData_q <= 8'h00;
      readValid_q <= 1'b0;
    end
    else
    begin
      slewA_q <= slewA_d;
      slewB_q <= slewB_d;
      transient_q <= transient_d;
      readData_q <= readData_d;
      readValid_q <= readValid_d;
    end
  end

  // A new ramp during the hold restarts the whole sequence, so the hold is always measured from the
  // last time the output settled.
  always_comb
  begin
    rampState_d = rampState_q;
    holdCount_d = holdCount_q;
    case (rampState_q)
      bgs_pkg::RAMP_IDLE:
      begin
        if (fallingSlewControlEnable && rampDownActive)
        begin
          rampState_d = bgs_pkg::RAMP_ACTIVE;
        end
      end
      bgs_pkg::RAMP_ACTIVE:
      begin
        if (!fallingSlewControlEnable)
        begin
          rampState_d = bgs_pkg::RAMP_IDLE;
        end
        else if (!rampDownActive)
        begin
          rampState_d = bgs_pkg::RAMP_HOLD;
          holdCount_d = 16'h0000;
        end
      end
      bgs_pkg::RAMP_HOLD:
      begin
        if (!fallingSlewControlEnable)
        begin
          rampState_d = bgs_pkg::RAMP_IDLE;
        end
        else if (rampDownActive)
        begin
          rampState_d = bgs_pkg::RAMP_ACTIVE;
        end
        else if (holdCount_q == HOLD_LAST)
        begin
          rampState_d = bgs_pkg::RAMP_IDLE;
        end
        else
        begin
          holdCount_d = holdCount_q + 16'h0001;
        end
      end
      default:
      begin
        rampState_d = bgs_pkg::RAMP_IDLE;
      end
    endcase
    force_d = (rampState_d != bgs_pkg::RAMP_IDLE);
  end

  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      rampState_q <= bgs_pkg::RAMP_IDLE;
      holdCount_q <= 16'h0000;
      force_q <= 1'b0;
    end
    else
    begin
      rampState_q <= rampState_d;
      holdCount_q <= holdCount_d;
      force_q <= force_d;
    end
  end

  assign slewSelects.shutdown = slewA_q[bgs_pkg::UPPER_SELECT_LSB +: bgs_pkg::SELECT_WIDTH];
  assign slewSelects.softstart = slewA_q[bgs_pkg::LOWER_SELECT_LSB +: bgs_pkg::SELECT_WIDTH];
  assign slewSelects.rampdown = slewB_q[bgs_pkg::UPPER_SELECT_LSB +: bgs_pkg::SELECT_WIDTH];
  assign slewSelects.rampup = slewB_q[bgs_pkg::LOWER_SELECT_LSB +: bgs_pkg::SELECT_WIDTH];
  assign positiveTransientBoostEnable = transient_q[bgs_pkg::POSITIVE_BOOST_BIT];
  assign negativeTransientBoostEnable = transient_q[bgs_pkg::NEGATIVE_BOOST_BIT];
  assign regReadData = readData_q;
  assign regReadValid = readValid_q;
  assign forceContinuousSwitching = force_q;

  bgs_slew_decode u_decode
  (
    .clock(clock),
    .rst_n(rst_n),
    .selects(slewSelects),
    .rates(slewRates)
  );

  property p_slewAReset;
    @(posedge clock) !rst_n |=> (slewA_q == bgs_pkg::RESET_SLEW_A && slewB_q == bgs_pkg::RESET_SLEW_B);
  endproperty
  a_slewAReset: assert property (p_slewAReset) else $error("Slew registers must reset to 0x24.");

  property p_slewAWrite;
    @(posedge clock) disable iff (!rst_n)
    (regReq.write && regReq.addr == bgs_pkg::OFFSET_SLEW_A)
      |=> (slewSelects.shutdown == $past(regReq.writeData[6:4]) && !slewA_q[7] && !slewA_q[3]);
  endproperty
  a_slewAWrite: assert property (p_slewAWrite) else $error("Shutdown select not taken from write.");

  property p_slewBWrite;
    @(posedge clock) disable iff (!rst_n)
    (regReq.write && regReq.addr == bgs_pkg::OFFSET_SLEW_B)
      |=> (slewSelects.rampup == $past(regReq.writeData[2:0]));
  endproperty
  a_slewBWrite: assert property (p_slewBWrite) else $error("Ramp-up select not taken from write.");

  property p_transientReserved;
    @(posedge clock) disable iff (!rst_n)
    (transient_q[7:2] == bgs_pkg::RESET_TRANSIENT[7:2]);
  endproperty
  a_transientReserved: assert property (p_transientReserved) else $error("Reserved bits left reset value.");

  property p_reservedReadZero;
    @(posedge clock) disable iff (!rst_n)
    (regReq.read && regReq.addr >= bgs_pkg::OFFSET_RESERVED_FIRST) |=> (regReadValid && regReadData == 8'h00);
  endproperty
  a_reservedReadZero: assert property (p_reservedReadZero) else $error("Reserved address read not zero.");

  property p_reservedWriteIgnored;
    @(posedge clock) disable iff (!rst_n)
    (regReq.write && regReq.addr >= bgs_pkg::OFFSET_RESERVED_FIRST)
      |=> ($stable(slewA_q) && $stable(slewB_q) && $stable(transient_q));
  endproperty
  a_reservedWriteIgnored: assert property (p_reservedWriteIgnored) else $error("Reserved write changed state.");

  property p_forcedDuringRamp;
    @(posedge clock) disable iff (!rst_n)
    (fallingSlewControlEnable && rampDownActive) [*2] |-> forceContinuousSwitching;
  endproperty
  a_forcedDuringRamp: assert property (p_forcedDuringRamp) else $error("Switching not forced during ramp.");

  property p_holdAfterRamp;
    @(posedge clock) disable iff (!rst_n)
    (forceContinuousSwitching && $fell(rampDownActive) && fallingSlewControlEnable)
      ##1 (fallingSlewControlEnable && !rampDownActive) [*3] |-> forceContinuousSwitching;
  endproperty
  a_holdAfterRamp: assert property (p_holdAfterRamp) else $error("Hold ended too early.");

  property p_holdBounded;
    @(posedge clock) disable iff (!rst_n)
    (rampState_q == bgs_pkg::RAMP_HOLD) |-> (holdCount_q <= HOLD_LAST);
  endproperty
  a_holdBounded: assert property (p_holdBounded) else $error("Hold counter passed its limit.");

  property p_disableReleases;
    @(posedge clock) disable iff (!rst_n)
    !fallingSlewControlEnable |=> !forceContinuousSwitching;
  endproperty
  a_disableReleases: assert property (p_disableReleases) else $error("Forced switching without enable.");

  c_rampAndHold: cover property (@(posedge clock) disable iff (!rst_n)
    (rampState_q == bgs_pkg::RAMP_HOLD) ##1 (rampState_q == bgs_pkg::RAMP_IDLE));
  c_writeTransient: cover property (@(posedge clock) disable iff (!rst_n)
    regReq.write && regReq.addr == bgs_pkg::OFFSET_TRANSIENT && regReq.writeData[1:0] == 2'h0);
  c_reservedRead: cover property (@(posedge clock) disable iff (!rst_n)
    regReq.read && regReq.addr == bgs_pkg::OFFSET_RESERVED_LAST);

endmodule // bgs_config_regs

//--- verification/tb_buck_global_slew_config_regs.sv
// Self-checking testbench for the buck global slew configuration register bank.
`timescale 1ns/10ps
module tb_buck_global_slew_config_regs;
  localparam int HOLD = 8;
  logic clock;
  logic rst_n;
  bgs_pkg::bgs_reg_req_type regReq;
  logic fallingSlewControlEnable;
  logic rampDownActive;
  logic [7:0] regReadData;
  logic regReadValid;
  bgs_pkg::bgs_slew_sel_type slewSelects;
  bgs_pkg::bgs_slew_rate_type slewRates;
  logic positiveTransientBoostEnable;
  logic negativeTransientBoostEnable;
  logic forceContinuousSwitching;
  logic [7:0] shA;
  logic [7:0] shB;
  logic [7:0] shT;
  int mismatches;
  int comparisons;

  bgs_config_regs #(.HOLD_CYCLES(HOLD)) dut_u
  (
    .clock(clock),
    .rst_n(rst_n),
    .regReq(regReq),
    .regReadData(regReadData),
    .regReadValid(regReadValid),
    .slewSelects(slewSelects),
    .slewRates(slewRates),
    .positiveTransientBoostEnable(positiveTransientBoostEnable),
    .negativeTransientBoostEnable(negativeTransientBoostEnable),
    .fallingSlewControlEnable(fallingSlewControlEnable),
    .rampDownActive(rampDownActive),
    .forceContinuousSwitching(forceContinuousSwitching)
  );

  initial
  begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  task automatic stop_test();
    if (mismatches == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp)
    begin
      $display("Error %s expected %h seen %h", name, exp, got);
      mismatches++;
    end
  endtask

  // Slew rate in units of 0.01 mV/us, worked out from the code table.
  function automatic logic [12:0] rateOf(input logic [2:0] c);
    case (c)
      3'h0: return 13'd125;
      3'h1: return 13'd250;
      3'h2: return 13'd500;
      3'h3: return 13'd1000;
      3'h4: return 13'd2000;
      3'h5: return 13'd4000;
      default: return 13'd6000;
    endcase
  endfunction

  function automatic logic [7:0] expRead(input logic [7:0] a);
    case (a)
      8'h33: return shA;
      8'h34: return shB;
      8'h35: return shT;
      default: return 8'h00;
    endcase
  endfunction

  task automatic shadowReset();
    shA = 8'h24;
    shB = 8'h24;
    shT = 8'h5f;
  endtask

  task automatic regWrite(input logic [7:0] a, input logic [7:0] d);
    @(negedge clock);
    regReq.addr = a;
    regReq.writeData = d;
    regReq.write = 1'b1;
    @(negedge clock);
    regReq.write = 1'b0;
    // Reserved bits keep their reset value whatever is written.
    if (a == 8'h33)
      shA = (shA & 8'h88) | (d & 8'h77);
    if (a == 8'h34)
      shB = (shB & 8'h88) | (d & 8'h77);
    if (a == 8'h35)
      shT = (shT & 8'hfc) | (d & 8'h03);
  endtask

  // A read with a simultaneous write when both is set; the read returns the old value.
  task automatic regRead(input logic [7:0] a, input logic both, input logic [7:0] d);
    logic [7:0] exp;
    exp = expRead(a);
    @(negedge clock);
    regReq.addr = a;
    regReq.writeData = d;
    regReq.read = 1'b1;
    regReq.write = both;
    @(negedge clock);
    regReq.read = 1'b0;
    regReq.write = 1'b0;
    check("readValid", 16'h1, 16'(regReadValid));
    check("readData", 16'(exp), 16'(regReadData));
    if (both && a == 8'h33)
      shA = (shA & 8'h88) | (d & 8'h77);
    @(negedge clock);
    check("readValidPulse", 16'h0, 16'(regReadValid));
  endtask

  task automatic checkOut();
    @(negedge clock);
    check("selects", 16'({shA[6:4], shA[2:0], shB[6:4], shB[2:0]}), 16'(slewSelects));
    check("rateShutdown", 16'(rateOf(shA[6:4])), 16'(slewRates.shutdown));
    check("rateSoftstart", 16'(rateOf(shA[2:0])), 16'(slewRates.softstart));
    check("rateRampdown", 16'(rateOf(shB[6:4])), 16'(slewRates.rampdown));
    check("rateRampup", 16'(rateOf(shB[2:0])), 16'(slewRates.rampup));
    check("positiveBoost", 16'(shT[1]), 16'(positiveTransientBoostEnable));
    check("negativeBoost", 16'(shT[0]), 16'(negativeTransientBoostEnable));
  endtask

  task automatic readAll();
    regRead(8'h33, 1'b0, 8'h00);
    regRead(8'h34, 1'b0, 8'h00);
    regRead(8'h35, 1'b0, 8'h00);
    checkOut();
  endtask

  // Counts the cycles that forced switching lasts after the ramp ends.
  task automatic holdLength(output int n);
    n = 0;
    rampDownActive = 1'b0;
    @(negedge clock);
    while (forceContinuousSwitching === 1'b1 && n < 4 * HOLD)
    begin
      n++;
      @(negedge clock);
    end
  endtask

  task automatic rampCheck(input logic restart);
    int n;
    rampDownActive = 1'b1;
    repeat (4) @(negedge clock);
    check("forceRamp", 16'h1, 16'(forceContinuousSwitching));
    if (restart)
    begin
      rampDownActive = 1'b0;
      repeat (3) @(negedge clock);
      rampDownActive = 1'b1;
      repeat (2) @(negedge clock);
    end
    holdLength(n);
    check("holdShort", 16'h1, 16'(n >= HOLD));
    check("holdLong", 16'h1, 16'(n <= HOLD + 1));
  endtask

  initial
  begin
    #200000;
    mismatches++;
    stop_test();
  end

  initial
  begin
    logic [7:0] a;
    mismatches = 0;
    comparisons = 0;
    rst_n = 1'b0;
    regReq = '0;
    fallingSlewControlEnable = 1'b0;
    rampDownActive = 1'b0;
    void'($urandom(74));
    shadowReset();
    repeat (8) @(negedge clock);
    rst_n = 1'b1;
    readAll();
    regWrite(8'h33, 8'hff);
    regWrite(8'h34, 8'h88);
    regWrite(8'h35, 8'h00);
    readAll();
    regWrite(8'h35, 8'hff);
    for (int c = 0; c < 8; c++)
    begin
      regWrite(8'h33, 8'(c * 17));
      regWrite(8'h34, 8'(c * 16 + 7 - c));
      checkOut();
    end
    regWrite(8'h36, 8'hff);
    regWrite(8'hff, 8'hff);
    regRead(8'h36, 1'b0, 8'h00);
    regRead(8'hff, 1'b0, 8'h00);
    regRead(8'h32, 1'b0, 8'h00);
    regRead(8'h33, 1'b1, 8'h51);
    regRead(8'h33, 1'b0, 8'h00);
    for (int i = 0; i < 300; i++)
    begin
      a = ($urandom_range(0, 3) == 0) ? 8'($urandom) : 8'(8'h32 + $urandom_range(0, 4));
      regWrite(a, 8'($urandom));
      regRead(8'(8'h32 + $urandom_range(0, 4)), 1'b0, 8'h00);
      checkOut();
    end
    @(negedge clock);
    rst_n = 1'b0;
    repeat (2) @(negedge clock);
    rst_n = 1'b1;
    shadowReset();
    readAll();
    rampDownActive = 1'b1;
    repeat (4) @(negedge clock);
    check("forceDisabled", 16'h0, 16'(forceContinuousSwitching));
    // The ramp stays active while the enable rises, so the first ramp check starts from a live ramp.
    fallingSlewControlEnable = 1'b1;
    rampCheck(1'b0);
    rampCheck(1'b1);
    rampDownActive = 1'b1;
    repeat (3) @(negedge clock);
    rampDownActive = 1'b0;
    repeat (2) @(negedge clock);
    fallingSlewControlEnable = 1'b0;
    repeat (2) @(negedge clock);
    check("forceAbort", 16'h0, 16'(forceContinuousSwitching));
    stop_test();
  end
endmodule // tb_buck_global_slew_config_regs
